// ---- testbench/txctm_partner.sv ----
// line-side serializer model that stalls at random
`timescale 1ns/1ps
`default_nettype none
module txctm_partner (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic valid_i,
    output logic      ready_o,
    output logic      acc_o
);
    // stalls a quarter of the time so the fifo backs up
    always_ff @(posedge clk_i) begin
        ready_o <= !rst_i && ($urandom % 4 != 0);
    end
    assign acc_o = valid_i & ready_o;
endmodule : txctm_partner
`default_nettype wire

// ---- testbench/txctm_top_bench.sv ----
// self-checking bench for the compliance test-mode generator
`timescale 1ns/1ps
`default_nettype none
module txctm_top_bench;
    // ------------------------------------------------------------
    // stimulus and model state
    // ------------------------------------------------------------
    logic        clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, berr;
    logic        nv = 1'b0, rv = 1'b0, ack, err, nrdy, sv, srdy, acc, idle, zero, dclk, cko, pd;
    logic [1:0]  op = 2'h2, gsel = 2'h0, ns = 2'h0, so;
    logic [11:0] addr = 12'h000;
    logic [15:0] wd = 16'h0000, rd, bcnt;
    logic [7:0]  rx = 8'h00, r;
    logic [2:0]  goe, gp, b;
    logic [10:0] scr;
    logic [1:0]  got[$], exp[$];
    logic [1:0]  t1[8] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0};
    logic [1:0]  t0[8] = '{2'h3, 2'h3, 2'h0, 2'h1, 2'h0, 2'h3, 2'h1, 2'h1};
    int          err_count = 0, num_checks = 0, n, bp = 0;
    always #5 clk = ~clk;
    txctm_top #(.FIFO_DEPTH(16)) u_txctm_top (
        .clk_i(clk), .rst_i(rst), .op_state_i(op), .mgmt_req_i(req), .mgmt_we_i(we),
        .mgmt_addr_i(addr), .mgmt_wdata_i(wd), .mgmt_ack_o(ack), .mgmt_err_o(err),
        .mgmt_rdata_o(rd), .gpio_sel_i(gsel), .nrm_sym_i(ns), .nrm_valid_i(nv),
        .nrm_ready_o(nrdy), .sym_o(so), .sym_valid_o(sv), .sym_ready_i(srdy),
        .pcs_idle_o(idle), .data_zero_o(zero), .rx_data_i(rx), .rx_valid_i(rv),
        .ber_err_o(berr), .ber_err_cnt_o(bcnt), .divided_test_clock_o(dclk),
        .clkout_o(cko), .gpio_o(gp), .gpio_oe_o(goe));
    txctm_partner u_txctm_partner (.clk_i(clk), .rst_i(rst), .valid_i(sv),
        .ready_o(srdy), .acc_o(acc));
    always @(posedge clk) if (acc) got.push_back(so);
    always @(posedge clk) if (berr) bp++;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic mg(input logic w, input logic [11:0] a, input logic [15:0] d, input logic e);
        @(posedge clk) {req, we, addr, wd} <= {1'b1, w, a, d};
        @(posedge clk) req <= 1'b0;
        #1 check("ack", {15'h0, ack}, 16'h0001);
        check("err", {15'h0, err}, {15'h0, e});
        if (!w) check("rdata", rd, d);
    endtask : mg
    task automatic cmp(input int k);
        for (int w = 0; w < 3000 && got.size() < k; w++) @(posedge clk);
        for (int i = 0; i < k; i++) check("sym", {14'h0, got[i]}, {14'h0, exp[i]});
        exp.delete();
    endtask : cmp
    // long wait so a mode with a 30-symbol period reaches its boundary under stalls
    task automatic drain();
        mg(1'b1, 12'h904, 16'h0000, 1'b0);
        repeat (100) @(posedge clk);
        got.delete();
    endtask : drain
    task automatic ck(input logic on);
        n = 0;
        b = 3'h0;
        repeat (2) @(posedge clk);
        repeat (12) begin
            @(posedge clk) pd = dclk;
            #1 check("clkout", {15'h0, cko}, {15'h0, pd & on});
            n += dclk;
            b += 3'(dclk != pd);
        end
        check("div", n[15:0], 16'h0006);
        check("div_edges", {13'h0, b}, 16'h0004);
    endtask : ck
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(10));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        mg(1'b0, 12'h904, 16'h0000, 1'b0);
        mg(1'b0, 12'h453, 16'h0000, 1'b0);
        mg(1'b0, 12'h123, 16'h0000, 1'b1);
        @(posedge clk) op <= 2'h3;
        mg(1'b1, 12'h904, 16'h4000, 1'b1);
        @(posedge clk) op <= 2'h1;
        mg(1'b0, 12'h904, 16'h0000, 1'b0);
        @(posedge clk) op <= 2'h2;
        for (int i = 0; i < 8; i++) begin
            ns <= ($urandom % 3 == 2) ? 2'h3 : 2'($urandom % 2);
            nv <= 1'b1;
            do @(posedge clk); while (!nrdy);
            exp.push_back(ns);
        end
        nv <= 1'b0;
        cmp(8);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) gsel <= 2'(s);
            repeat (2) @(posedge clk);
            #1 check("gpio_oe", {13'h0, goe}, s ? 16'(3'h1 << (s - 1)) : 16'h0);
            b = gp;
            @(posedge clk);
            #1 check("gpio_tog", {13'h0, gp ^ b}, s ? 16'(3'h1 << (s - 1)) : 16'h0);
        end
        mg(1'b1, 12'h453, 16'h0019, 1'b0);
        mg(1'b0, 12'h453, 16'h0019, 1'b0);
        ck(1'b0);
        drain();
        scr = 11'h7ff;
        for (int i = 0; i < 12; i++) begin
            b = {scr[1] ^ scr[5], scr[1] ^ scr[4], scr[0]};
            exp.push_back(t1[b]);
            exp.push_back(t0[b]);
            scr = {scr[9:0], scr[10] ^ scr[8]};
        end
        mg(1'b1, 12'h904, 16'h8000, 1'b0);
        cmp(24);
        ck(1'b1);
        drain();
        for (int i = 0; i < 12; i++) exp.push_back(i % 6 < 3 ? 2'h1 : 2'h3);
        mg(1'b1, 12'h904, 16'h4000, 1'b0);
        cmp(12);
        drain();
        for (int i = 0; i < 60; i++) exp.push_back(i % 30 < 15 ? 2'h1 : 2'h3);
        mg(1'b1, 12'h904, 16'hc000, 1'b0);
        cmp(60);
        drain();
        mg(1'b1, 12'h904, 16'h2000, 1'b0);
        ck(1'b1);
        mg(1'b1, 12'h904, 16'ha000, 1'b0);
        repeat (3) @(posedge clk);
        #1 check("pcs_idle", {15'h0, idle}, 16'h0001);
        mg(1'b1, 12'h904, 16'he000, 1'b0);
        repeat (3) @(posedge clk);
        #1 check("data_zero", {15'h0, zero}, 16'h0001);
        check("pcs_idle_off", {15'h0, idle}, 16'h0000);
        n = 0;
        for (int i = 0; i < 10; i++) begin
            r = ($urandom % 2) ? 8'($urandom) : 8'h00;
            @(posedge clk) {rv, rx} <= {1'b1, r};
            n += (r != 8'h00);
        end
        @(posedge clk) rv <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("ber_cnt", bcnt, 16'(n));
        check("ber_pulses", bp[15:0], 16'(n));
        results();
    end
    initial begin
        #300000;
        err_count++;
        results();
    end
endmodule : txctm_top_bench
`default_nettype wire

// ---- verilog/txctm_fifo.sv ----
// symbol fifo between the pattern sources and the line serializer
`timescale 1ns/1ps
`default_nettype none
module txctm_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic [WIDTH-1:0]           in_data_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    output logic [WIDTH-1:0]                out_data_o,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [$clog2(DEPTH+1)-1:0]      count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic [CW-1:0]    cnt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt != CW'(DEPTH));
    assign out_valid_o = (cnt != '0);
    assign out_data_o  = mem[rd_idx];
    assign count_o     = cnt;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_idx] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_idx <= '0;
            rd_idx <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + AW'(1);
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + AW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (push && !pop) begin
            cnt <= cnt + CW'(1);
        end else if (pop && !push) begin
            cnt <= cnt - CW'(1);
        end
    end
endmodule : txctm_fifo
`default_nettype wire

// ---- verilog/txctm_pkg.sv ----
// constants, codes and types of the transmitter compliance test-mode block
`default_nettype none
package txctm_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 16;
    localparam logic [11:0] AUX_CLK_SEL_OFS = 12'h453;
    localparam logic [11:0] TEST_CTL_OFS    = 12'h904;
    localparam logic [15:0] AUX_CLK_RST     = 16'h0000;
    localparam logic [15:0] TEST_CTL_RST    = 16'h0000;
    localparam logic [15:0] AUX_CLK_TCLK    = 16'h0019;
    localparam logic [15:0] CODE_TM1        = 16'h2000;
    localparam logic [15:0] CODE_TM2        = 16'h4000;
    localparam logic [15:0] CODE_TM4        = 16'h8000;
    localparam logic [15:0] CODE_TM5        = 16'ha000;
    localparam logic [15:0] CODE_TM6        = 16'hc000;
    localparam logic [15:0] CODE_TM7        = 16'he000;
    // ------------------------------------------------------------
    // pattern and divider counts
    // ------------------------------------------------------------
    localparam logic [4:0]  SQ2_HALF        = 5'h03;
    localparam logic [4:0]  SQ6_HALF        = 5'h0f;
    localparam logic [4:0]  TM4_LAST        = 5'h01;
    localparam logic [2:0]  TCLK_DIV        = 3'h6;
    localparam logic [2:0]  TCLK_DIV_HALF   = 3'h3;
    localparam logic [10:0] SCR_SEED        = 11'h7ff;
    localparam logic [15:0] BER_CNT_RST     = 16'h0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SYM_ZERO  = 2'b00,
        SYM_PLUS  = 2'b01,
        SYM_MINUS = 2'b11
    } txctm_sym_t;
    typedef enum logic [2:0] {
        M_NRM = 3'b000,
        M_TM1 = 3'b001,
        M_TM2 = 3'b010,
        M_TM4 = 3'b011,
        M_TM5 = 3'b100,
        M_TM6 = 3'b101,
        M_TM7 = 3'b110
    } txctm_mode_t;
    typedef enum logic [1:0] {
        OP_OFF     = 2'b00,
        OP_STANDBY = 2'b01,
        OP_NORMAL  = 2'b10,
        OP_SLEEP   = 2'b11
    } txctm_op_t;
endpackage : txctm_pkg
`default_nettype wire

// ---- verilog/txctm_top.sv ----
// transmitter compliance test-mode generator with management registers
`timescale 1ns/1ps
`default_nettype none
module txctm_top #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [1:0]  op_state_i,
    input  wire logic        mgmt_req_i,
    input  wire logic        mgmt_we_i,
    input  wire logic [11:0] mgmt_addr_i,
    input  wire logic [15:0] mgmt_wdata_i,
    output logic             mgmt_ack_o,
    output logic             mgmt_err_o,
    output logic [15:0]      mgmt_rdata_o,
    input  wire logic [1:0]  gpio_sel_i,
    input  wire logic [1:0]  nrm_sym_i,
    input  wire logic        nrm_valid_i,
    output logic             nrm_ready_o,
    output logic [1:0]       sym_o,
    output logic             sym_valid_o,
    input  wire logic        sym_ready_i,
    output logic             pcs_idle_o,
    output logic             data_zero_o,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    output logic             ber_err_o,
    output logic [15:0]      ber_err_cnt_o,
    output logic             divided_test_clock_o,
    output logic             clkout_o,
    output logic [2:0]       gpio_o,
    output logic [2:0]       gpio_oe_o
);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    logic [15:0]              test_ctl;
    logic [15:0]              aux_clk_sel;
    txctm_pkg::txctm_mode_t   active_mode;
    txctm_pkg::txctm_mode_t   pend_mode;
    txctm_pkg::txctm_mode_t   next_active;
    logic [4:0]               gen_cnt;
    logic [4:0]               gen_last;
    logic [10:0]              scr;
    logic [2:0]               grp;
    txctm_pkg::txctm_sym_t    t1_sym;
    txctm_pkg::txctm_sym_t    t0_sym;
    txctm_pkg::txctm_sym_t    gen_sym;
    logic                     gen_mode;
    logic                     gen_push;
    logic                     nrm_push;
    logic                     switch_ok;
    logic                     mgmt_ok;
    logic [1:0]               fifo_in_data;
    logic                     fifo_in_ready;
    logic [1:0]               fifo_out_data;
    logic                     fifo_out_valid;
    logic                     fifo_pop;
    logic [CW-1:0]            fifo_count;
    logic [2:0]               dcnt;
    logic [2:0]               next_dcnt;
    logic                     dclk;
    logic                     tclk;
    logic                     clk_route;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // management registers
    // ------------------------------------------------------------
    assign mgmt_ok = (op_state_i == txctm_pkg::OP_STANDBY) ||
                     (op_state_i == txctm_pkg::OP_NORMAL);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_ctl    <= txctm_pkg::TEST_CTL_RST;
            aux_clk_sel <= txctm_pkg::AUX_CLK_RST;
        end else if (mgmt_req_i && mgmt_we_i && mgmt_ok) begin
            if (mgmt_addr_i == txctm_pkg::TEST_CTL_OFS) begin
                test_ctl <= mgmt_wdata_i;
            end
            if (mgmt_addr_i == txctm_pkg::AUX_CLK_SEL_OFS) begin
                aux_clk_sel <= mgmt_wdata_i;
            end
        end
    end

    // sleep and power-off refuse access; unmapped reads return zero with error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mgmt_ack_o   <= 1'b0;
            mgmt_err_o   <= 1'b0;
            mgmt_rdata_o <= '0;
        end else begin
            mgmt_ack_o   <= mgmt_req_i;
            mgmt_err_o   <= 1'b0;
            mgmt_rdata_o <= '0;
            if (mgmt_req_i) begin
                if (!mgmt_ok) begin
                    mgmt_err_o <= 1'b1;
                end else if (mgmt_addr_i == txctm_pkg::TEST_CTL_OFS) begin
                    mgmt_rdata_o <= test_ctl;
                end else if (mgmt_addr_i == txctm_pkg::AUX_CLK_SEL_OFS) begin
                    mgmt_rdata_o <= aux_clk_sel;
                end else begin
                    mgmt_err_o <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // mode decode and boundary switching
    // ------------------------------------------------------------
    always_comb begin
        case (test_ctl)
            txctm_pkg::CODE_TM1: pend_mode = txctm_pkg::M_TM1;
            txctm_pkg::CODE_TM2: pend_mode = txctm_pkg::M_TM2;
            txctm_pkg::CODE_TM4: pend_mode = txctm_pkg::M_TM4;
            txctm_pkg::CODE_TM5: pend_mode = txctm_pkg::M_TM5;
            txctm_pkg::CODE_TM6: pend_mode = txctm_pkg::M_TM6;
            txctm_pkg::CODE_TM7: pend_mode = txctm_pkg::M_TM7;
            default:             pend_mode = txctm_pkg::M_NRM;
        endcase
    end

    assign gen_mode = (active_mode == txctm_pkg::M_TM2) ||
                      (active_mode == txctm_pkg::M_TM4) ||
                      (active_mode == txctm_pkg::M_TM6);

    always_comb begin
        case (active_mode)
            txctm_pkg::M_TM2: gen_last = 5'(2 * txctm_pkg::SQ2_HALF - 1);
            txctm_pkg::M_TM6: gen_last = 5'(2 * txctm_pkg::SQ6_HALF - 1);
            txctm_pkg::M_TM4: gen_last = txctm_pkg::TM4_LAST;
            default:          gen_last = '0;
        endcase
    end

    assign gen_push  = gen_mode && fifo_in_ready;
    // a pattern is only left after its last symbol, never part way through
    assign switch_ok = !gen_mode || (gen_push && gen_cnt == gen_last) ||
                       (!gen_push && gen_cnt == '0);
    assign next_active = switch_ok ? pend_mode : active_mode;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_mode <= txctm_pkg::M_NRM;
        end else begin
            active_mode <= next_active;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_cnt <= '0;
        end else if (switch_ok && gen_push) begin
            gen_cnt <= '0;
        end else if (gen_push) begin
            gen_cnt <= gen_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // pattern generator
    // ------------------------------------------------------------
    assign grp = {scr[1] ^ scr[5], scr[1] ^ scr[4], scr[0]};

    always_comb begin
        case (grp)
            3'b000: begin t1_sym = txctm_pkg::SYM_MINUS; t0_sym = txctm_pkg::SYM_MINUS; end
            3'b001: begin t1_sym = txctm_pkg::SYM_ZERO;  t0_sym = txctm_pkg::SYM_MINUS; end
            3'b010: begin t1_sym = txctm_pkg::SYM_MINUS; t0_sym = txctm_pkg::SYM_ZERO;  end
            3'b011: begin t1_sym = txctm_pkg::SYM_MINUS; t0_sym = txctm_pkg::SYM_PLUS;  end
            3'b100: begin t1_sym = txctm_pkg::SYM_PLUS;  t0_sym = txctm_pkg::SYM_ZERO;  end
            3'b101: begin t1_sym = txctm_pkg::SYM_PLUS;  t0_sym = txctm_pkg::SYM_MINUS; end
            3'b110: begin t1_sym = txctm_pkg::SYM_PLUS;  t0_sym = txctm_pkg::SYM_PLUS;  end
            default: begin t1_sym = txctm_pkg::SYM_ZERO; t0_sym = txctm_pkg::SYM_PLUS;  end
        endcase
    end

    always_comb begin
        case (active_mode)
            txctm_pkg::M_TM2: gen_sym = (gen_cnt < txctm_pkg::SQ2_HALF) ?
                                        txctm_pkg::SYM_PLUS : txctm_pkg::SYM_MINUS;
            txctm_pkg::M_TM6: gen_sym = (gen_cnt < txctm_pkg::SQ6_HALF) ?
                                        txctm_pkg::SYM_PLUS : txctm_pkg::SYM_MINUS;
            txctm_pkg::M_TM4: gen_sym = (gen_cnt == '0) ? t1_sym : t0_sym;
            default:          gen_sym = txctm_pkg::SYM_ZERO;
        endcase
    end

    // one scrambler step per (T1,T0) pair, taken after T0 leaves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scr <= txctm_pkg::SCR_SEED;
        end else if (gen_push && active_mode == txctm_pkg::M_TM4 &&
                     gen_cnt == txctm_pkg::TM4_LAST) begin
            scr <= {scr[9:0], scr[10] ^ scr[8]};
        end
    end

    // ------------------------------------------------------------
    // normal path hand-off
    // ------------------------------------------------------------
    // ready is registered, so it leaves two slots of margin for the late view
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nrm_ready_o <= 1'b0;
        end else begin
            nrm_ready_o <= (next_active == txctm_pkg::M_NRM ||
                            next_active == txctm_pkg::M_TM1 ||
                            next_active == txctm_pkg::M_TM5 ||
                            next_active == txctm_pkg::M_TM7) &&
                           (fifo_count < CW'(FIFO_DEPTH - 2));
        end
    end

    assign nrm_push     = nrm_valid_i && nrm_ready_o;
    assign fifo_in_data = gen_push ? gen_sym : nrm_sym_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcs_idle_o  <= 1'b0;
            data_zero_o <= 1'b0;
        end else begin
            pcs_idle_o  <= (active_mode == txctm_pkg::M_TM5);
            data_zero_o <= (active_mode == txctm_pkg::M_TM7);
        end
    end

    // ------------------------------------------------------------
    // symbol fifo and output stage
    // ------------------------------------------------------------
    txctm_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (fifo_in_data),
        .in_valid_i  (gen_push || nrm_push),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .count_o     (fifo_count)
    );

    assign fifo_pop = fifo_out_valid && (!sym_valid_o || sym_ready_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sym_o       <= txctm_pkg::SYM_ZERO;
            sym_valid_o <= 1'b0;
        end else if (fifo_pop) begin
            sym_o       <= fifo_out_data;
            sym_valid_o <= 1'b1;
        end else if (sym_ready_i) begin
            sym_valid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // zero-data error check
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ber_err_o     <= 1'b0;
            ber_err_cnt_o <= txctm_pkg::BER_CNT_RST;
        end else begin
            ber_err_o <= (active_mode == txctm_pkg::M_TM7) && rx_valid_i &&
                         (rx_data_i != '0);
            if (next_active == txctm_pkg::M_TM7 && active_mode != txctm_pkg::M_TM7) begin
                ber_err_cnt_o <= txctm_pkg::BER_CNT_RST;
            end else if (active_mode == txctm_pkg::M_TM7 && rx_valid_i &&
                         rx_data_i != '0 && ber_err_cnt_o != 16'hffff) begin
                ber_err_cnt_o <= ber_err_cnt_o + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // test clocks and pin routing
    // ------------------------------------------------------------
    assign next_dcnt = (dcnt == txctm_pkg::TCLK_DIV - 3'h1) ? 3'h0 : dcnt + 3'h1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // start on the last count so the first high phase after reset is full length
            dcnt <= txctm_pkg::TCLK_DIV - 3'h1;
            dclk <= 1'b0;
            tclk <= 1'b0;
        end else begin
            dcnt <= next_dcnt;
            dclk <= (next_dcnt < txctm_pkg::TCLK_DIV_HALF);
            tclk <= ~tclk;
        end
    end

    assign divided_test_clock_o = dclk;
    assign clk_route = (active_mode == txctm_pkg::M_TM1) ||
                       (active_mode == txctm_pkg::M_TM4 &&
                        aux_clk_sel == txctm_pkg::AUX_CLK_TCLK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clkout_o <= 1'b0;
        end else begin
            clkout_o <= clk_route && dclk;
        end
    end

    // pin select 0 leaves all three pins undriven
    for (genvar g = 0; g < 3; g++) begin : g_gpio
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                gpio_o[g]    <= 1'b0;
                gpio_oe_o[g] <= 1'b0;
            end else begin
                gpio_oe_o[g] <= (gpio_sel_i == 2'(g + 1));
                gpio_o[g]    <= (gpio_sel_i == 2'(g + 1)) && tclk;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_no_rise5;
        !$rose(dclk) [*5];
    endsequence

    chk_div_sixth: assert property ($rose(dclk) |=> s_no_rise5 ##1 $rose(dclk))
        else $error("divided clock period is not six cycles");
    chk_clkout_route: assert property (clk_route |=> clkout_o == $past(dclk))
        else $error("clkout does not follow the divided clock");
    chk_gpio_pin: assert property (gpio_sel_i == 2'h2 |=> gpio_oe_o == 3'b010)
        else $error("selected pin is not driven");
    chk_mode_decode: assert property (test_ctl == txctm_pkg::CODE_TM6 |->
                                      pend_mode == txctm_pkg::M_TM6)
        else $error("test mode code not decoded");
    chk_sq2_shape: assert property (active_mode == txctm_pkg::M_TM2 && gen_push |->
                   (gen_sym == txctm_pkg::SYM_PLUS) == (gen_cnt < 5'h03))
        else $error("mode 2 pattern shape wrong");
    chk_sq6_wrap: assert property (active_mode == txctm_pkg::M_TM6 && gen_push &&
                  gen_cnt == 5'h1d && pend_mode == txctm_pkg::M_TM6 |=> gen_cnt == 5'h00)
        else $error("mode 6 period is not thirty symbols");
    chk_scr_step: assert property (active_mode == txctm_pkg::M_TM4 && gen_push &&
                  gen_cnt == 5'h01 |=> scr == {$past(scr[9:0]), $past(scr[10] ^ scr[8])})
        else $error("scrambler step wrong");
    chk_tm4_pair: assert property (active_mode == txctm_pkg::M_TM4 && gen_push &&
                  gen_cnt == 5'h00 && grp == 3'b110 |-> gen_sym == txctm_pkg::SYM_PLUS)
        else $error("mode 4 symbol map wrong");
    chk_ber_flag: assert property (active_mode == txctm_pkg::M_TM7 && rx_valid_i &&
                  rx_data_i != 8'h00 |=> ber_err_o)
        else $error("non-zero received data not flagged");
    chk_mgmt_gate: assert property (mgmt_req_i && mgmt_we_i && !mgmt_ok |=>
                   $stable(test_ctl) && mgmt_err_o)
        else $error("register written outside standby or normal");
    chk_mode_bound: assert property (active_mode != $past(active_mode) |->
                    gen_cnt == 5'h00)
        else $error("mode changed inside a pattern");
endmodule : txctm_top
`default_nettype wire
